// [hdl/cprs_pkg.sv]
package cprs_pkg;

    // ---------------------------------------------------------------
    // register word indices (byte address = 4 * index)
    // ---------------------------------------------------------------
    localparam logic [5:0] CPRS_IDX_CONTROL = 6'h00;
    localparam logic [5:0] CPRS_IDX_STATUS = 6'h01;
    localparam logic [5:0] CPRS_IDX_IRQ_STAT = 6'h02;
    localparam logic [5:0] CPRS_IDX_IRQ_MASK = 6'h03;
    localparam logic [5:0] CPRS_IDX_PCE2 = 6'h0D;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CPRS_CTL_WAIT_DIS = 0;
    localparam int CPRS_CTL_STOP_DIS = 1;
    localparam int CPRS_CTL_LOCK = 2;
    localparam int CPRS_CTL_SWRST = 3;
    localparam int CPRS_STAT_MODE_LSB = 0;
    localparam int CPRS_STAT_SECURE = 2;
    localparam int CPRS_STAT_READY = 3;
    localparam int CPRS_PCE2_SECOND_CAN_CLOCK_ENABLE = 0;
    localparam int CPRS_IRQ_WAIT_WAKE = 0;
    localparam int CPRS_IRQ_STOP_WAKE = 1;
    localparam int CPRS_IRQ_SEQ_DONE = 2;
    localparam int CPRS_IRQ_WDOG = 3;
    localparam int CPRS_IRQ_W = 4;

    // ---------------------------------------------------------------
    // reset values and keys
    // ---------------------------------------------------------------
    localparam logic CPRS_PCE2_RST = 1'b1;
    localparam logic [3:0] CPRS_IRQ_MASK_RST = 4'h0;
    // arbitrary value: flash security bytes that turn security on
    localparam logic [15:0] CPRS_SEC_LOCK_KEY = 16'hE70A;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CPRS_MCLK_MAX_MHZ = 120;
    localparam int CPRS_SYS_DIV = 2;
    localparam int CPRS_SYS_MAX_MHZ = CPRS_MCLK_MAX_MHZ / CPRS_SYS_DIV;
    localparam int CPRS_POR_EXTEND_CYCLES = 2097152;
    localparam int CPRS_WINDOW_CYCLES = 32;
    localparam int CPRS_CNT_W = 21;
    localparam logic [20:0] CPRS_WINDOW_LAST = 21'(CPRS_WINDOW_CYCLES - 1);

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        CPRS_SQ_EXTEND,
        CPRS_SQ_CLKINIT,
        CPRS_SQ_PERIPH,
        CPRS_SQ_CORE,
        CPRS_SQ_RUN
    } cprs_seq_t;

    typedef enum logic [1:0] {
        CPRS_MD_RUN,
        CPRS_MD_WAIT,
        CPRS_MD_STOP
    } cprs_mode_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cprs_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } cprs_wb_rsp_t;

    typedef struct packed {
        logic core;
        logic periph;
        logic second_can_clock_enable;
    } cprs_clk_en_t;

    typedef struct packed {
        cprs_seq_t seq;
        logic [20:0] cnt;
        cprs_mode_t mode;
        logic div;
        cprs_clk_en_t clk;
        logic pce2;
        logic wait_dis;
        logic stop_dis;
        logic lock;
        logic secure;
        logic dbg_dis;
        logic [3:0] stat;
        logic [3:0] mask;
        logic irq;
        logic ack;
        logic [15:0] rdat;
        logic [2:0] can_s;
        logic [2:0] nci_s;
        logic can_l;
        logic nci_l;
        logic sim_run;
        logic per_rst_n;
        logic core_rst_n;
        logic jtag_on;
    } cprs_state_t;

    localparam cprs_state_t CPRS_STATE_RST = '{
        seq: CPRS_SQ_EXTEND,
        mode: CPRS_MD_RUN,
        pce2: CPRS_PCE2_RST,
        mask: CPRS_IRQ_MASK_RST,
        default: '0
    };

endpackage : cprs_pkg

// [hdl/cprs_top.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1: control bit 0 of gate register two passes the second CAN clock.
// RQ2: bits 15 to 1 of gate register two read zero, ignore writes.
// RQ3: core, memory and peripheral clocks run at half the master clock.
// RQ4: peripherals clock from the peripheral bus clock equal to processor clock.
// RQ5: run mode keeps core and peripheral clocks active.
// RQ6: wait stops core clocks; unmasked peripheral interrupt wakes the core.
// RQ7: stop exits only on CAN traffic, async interrupt, watchdog, external or power-on reset; code also exits on a software reset write.
// RQ8: software must switch off the PLL itself before stop.
// RQ9: software can disable stop and wait; even locked disable clears at reset.
// RQ10: reset sources: external pin, power-on, software write, watchdog.
// RQ11: power-on reset extends 2^21 cycles, then three 32-cycle release windows.
// RQ12: reset asserts asynchronously, releases on a rising clock edge.
// RQ13: boot selects secure or unsecured mode from flash security setting.
// RQ14: only two flash security bytes decide security.
// RQ15: security disables core debug, execution unaffected.
// RQ16: flash security bytes set the debug memory-read block at reset.
// RQ17: JTAG test access port active from boot.
// RQ18: disabled stop or wait instruction suspends nothing, execution continues.
module cprs_top
    import cprs_pkg::*;
#(
    parameter int POR_EXTEND_CYCLES = CPRS_POR_EXTEND_CYCLES
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic por_n,
    input wire logic clk_en,
    input wire cprs_wb_req_t wb_req_i,
    output var cprs_wb_rsp_t wb_rsp_o,
    input wire logic watchdog_rst_i,
    input wire logic stop_req_i,
    input wire logic wait_req_i,
    input wire logic periph_irq_i,
    input wire logic can_wake_i,
    input wire logic nonclk_irq_i,
    input wire logic [15:0] flash_sec_i,
    output var cprs_clk_en_t clk_en_o,
    output logic sim_clk_run_o,
    output logic periph_rst_n_o,
    output logic core_rst_n_o,
    output logic mem_read_block_o,
    output logic debug_disable_o,
    output logic jtag_active_o,
    output logic [1:0] power_mode_o,
    output logic irq_o
);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n_s;
    logic por_mark_r;

    always_ff @(posedge mclk or negedge reset_n or negedge por_n) begin
        if (!reset_n || !por_n) begin
            rst_sync_r <= 2'b00; // RQ12 RQ10
        end else if (clk_en) begin
            rst_sync_r <= {rst_sync_r[0], 1'b1}; // RQ12
        end
    end

    assign rst_n_s = rst_sync_r[1];

    cprs_state_t st_r;
    cprs_state_t st_nxt;

    // marks a power-on cause so only that cause gets the long extension
    always_ff @(posedge mclk or negedge por_n) begin
        if (!por_n) begin
            por_mark_r <= 1'b1; // RQ11
        end else if (clk_en && rst_n_s && st_r.seq == CPRS_SQ_CLKINIT) begin
            por_mark_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    logic req;
    logic wr;
    logic [5:0] idx;
    logic sw_rst;
    logic [3:0] ev;
    logic [3:0] clr;
    logic [15:0] rd;

    always_comb begin
        st_nxt = st_r;
        req = wb_req_i.cyc & wb_req_i.stb & ~st_r.ack;
        wr = req & wb_req_i.we & wb_req_i.sel[0];
        idx = wb_req_i.adr[7:2];
        sw_rst = 1'b0;
        ev = 4'h0;
        clr = 4'h0;
        rd = 16'h0000;
        st_nxt.ack = req;
        st_nxt.div = ~st_r.div; // RQ3
        st_nxt.jtag_on = 1'b1; // RQ17

        // pin inputs: three stages, accept when stages two and three agree
        st_nxt.can_s = {st_r.can_s[1:0], can_wake_i};
        st_nxt.nci_s = {st_r.nci_s[1:0], nonclk_irq_i};
        if (st_r.can_s[1] == st_r.can_s[2]) begin
            st_nxt.can_l = st_r.can_s[2];
        end
        if (st_r.nci_s[1] == st_r.nci_s[2]) begin
            st_nxt.nci_l = st_r.nci_s[2];
        end

        // -----------------------------------------------------------
        // register reads
        // -----------------------------------------------------------
        if (idx == CPRS_IDX_CONTROL) begin
            rd[CPRS_CTL_WAIT_DIS] = st_r.wait_dis;
            rd[CPRS_CTL_STOP_DIS] = st_r.stop_dis;
            rd[CPRS_CTL_LOCK] = st_r.lock;
        end else if (idx == CPRS_IDX_STATUS) begin
            rd[CPRS_STAT_MODE_LSB +: 2] = st_r.mode;
            rd[CPRS_STAT_SECURE] = st_r.secure;
            rd[CPRS_STAT_READY] = st_r.core_rst_n;
        end else if (idx == CPRS_IDX_IRQ_STAT) begin
            rd[CPRS_IRQ_W-1:0] = st_r.stat;
        end else if (idx == CPRS_IDX_IRQ_MASK) begin
            rd[CPRS_IRQ_W-1:0] = st_r.mask;
        end else if (idx == CPRS_IDX_PCE2) begin
            rd[CPRS_PCE2_SECOND_CAN_CLOCK_ENABLE] = st_r.pce2; // RQ2
        end
        if (req) begin
            st_nxt.rdat = rd;
        end

        // -----------------------------------------------------------
        // register writes
        // -----------------------------------------------------------
        if (wr) begin
            if (idx == CPRS_IDX_CONTROL) begin
                // once locked, disables can be set but not cleared
                if (st_r.lock) begin
                    st_nxt.wait_dis = st_r.wait_dis | wb_req_i.dat[CPRS_CTL_WAIT_DIS]; // RQ9
                    st_nxt.stop_dis = st_r.stop_dis | wb_req_i.dat[CPRS_CTL_STOP_DIS];
                end else begin
                    st_nxt.wait_dis = wb_req_i.dat[CPRS_CTL_WAIT_DIS]; // RQ9
                    st_nxt.stop_dis = wb_req_i.dat[CPRS_CTL_STOP_DIS];
                end
                st_nxt.lock = st_r.lock | wb_req_i.dat[CPRS_CTL_LOCK];
                sw_rst = wb_req_i.dat[CPRS_CTL_SWRST]; // RQ10
            end else if (idx == CPRS_IDX_IRQ_STAT) begin
                clr = wb_req_i.dat[CPRS_IRQ_W-1:0];
            end else if (idx == CPRS_IDX_IRQ_MASK) begin
                st_nxt.mask = wb_req_i.dat[CPRS_IRQ_W-1:0];
            end else if (idx == CPRS_IDX_PCE2) begin
                st_nxt.pce2 = wb_req_i.dat[CPRS_PCE2_SECOND_CAN_CLOCK_ENABLE]; // RQ1 RQ2
            end
        end

        // -----------------------------------------------------------
        // reset release sequence
        // -----------------------------------------------------------
        case (st_r.seq)
            CPRS_SQ_EXTEND: begin
                if (!por_mark_r || st_r.cnt == 21'(POR_EXTEND_CYCLES - 1)) begin
                    st_nxt.seq = CPRS_SQ_CLKINIT; // RQ11
                    st_nxt.cnt = '0;
                end else begin
                    st_nxt.cnt = st_r.cnt + 21'h000001;
                end
            end
            CPRS_SQ_CLKINIT: begin
                st_nxt.sim_run = 1'b1;
                if (st_r.cnt == CPRS_WINDOW_LAST) begin
                    st_nxt.seq = CPRS_SQ_PERIPH; // RQ11
                    st_nxt.cnt = '0;
                    st_nxt.per_rst_n = 1'b1;
                    // flash presents its security state as peripherals leave reset
                    st_nxt.secure = (flash_sec_i == CPRS_SEC_LOCK_KEY); // RQ13 RQ14 RQ16
                end else begin
                    st_nxt.cnt = st_r.cnt + 21'h000001;
                end
            end
            CPRS_SQ_PERIPH: begin
                if (st_r.cnt == CPRS_WINDOW_LAST) begin
                    st_nxt.seq = CPRS_SQ_CORE; // RQ11
                    st_nxt.cnt = '0;
                    st_nxt.dbg_dis = st_r.secure; // RQ15
                end else begin
                    st_nxt.cnt = st_r.cnt + 21'h000001;
                end
            end
            CPRS_SQ_CORE: begin
                if (st_r.cnt == CPRS_WINDOW_LAST) begin
                    st_nxt.seq = CPRS_SQ_RUN; // RQ11
                    st_nxt.cnt = '0;
                    st_nxt.core_rst_n = 1'b1;
                    ev[CPRS_IRQ_SEQ_DONE] = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt + 21'h000001;
                end
            end
            default: begin
            end
        endcase

        // -----------------------------------------------------------
        // power modes
        // -----------------------------------------------------------
        case (st_r.mode)
            CPRS_MD_RUN: begin
                // a disabled instruction falls through as a no-op
                if (st_r.core_rst_n && stop_req_i && !st_r.stop_dis) begin
                    st_nxt.mode = CPRS_MD_STOP; // RQ18
                end else if (st_r.core_rst_n && wait_req_i && !st_r.wait_dis) begin
                    st_nxt.mode = CPRS_MD_WAIT; // RQ18
                end
            end
            CPRS_MD_WAIT: begin
                if (periph_irq_i) begin
                    st_nxt.mode = CPRS_MD_RUN; // RQ6
                    ev[CPRS_IRQ_WAIT_WAKE] = 1'b1;
                end
            end
            default: begin
                if (st_r.can_l || st_r.nci_l) begin
                    st_nxt.mode = CPRS_MD_RUN; // RQ7
                    ev[CPRS_IRQ_STOP_WAKE] = 1'b1;
                end
            end
        endcase

        // -----------------------------------------------------------
        // synchronous resets: software and watchdog
        // -----------------------------------------------------------
        if (sw_rst || watchdog_rst_i) begin
            st_nxt.seq = CPRS_SQ_CLKINIT; // RQ10
            st_nxt.cnt = '0;
            st_nxt.per_rst_n = 1'b0;
            st_nxt.core_rst_n = 1'b0;
            st_nxt.mode = CPRS_MD_RUN; // RQ7
            st_nxt.wait_dis = 1'b0; // RQ9
            st_nxt.stop_dis = 1'b0;
            st_nxt.lock = 1'b0;
            st_nxt.pce2 = CPRS_PCE2_RST;
            ev[CPRS_IRQ_WDOG] = watchdog_rst_i;
        end

        // -----------------------------------------------------------
        // clock enables at half rate
        // -----------------------------------------------------------
        st_nxt.clk.core = ~st_r.div & st_nxt.sim_run & (st_nxt.mode == CPRS_MD_RUN); // RQ3 RQ5 RQ6
        st_nxt.clk.periph = ~st_r.div & st_nxt.sim_run & (st_nxt.mode != CPRS_MD_STOP); // RQ4 RQ5
        st_nxt.clk.second_can_clock_enable = st_nxt.clk.periph & st_nxt.pce2; // RQ1

        // hardware set beats the software clear
        st_nxt.stat = (st_r.stat & ~clr) | ev;
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    end

    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            st_r <= CPRS_STATE_RST;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign wb_rsp_o.ack = st_r.ack;
    assign wb_rsp_o.dat = {16'h0000, st_r.rdat};
    assign clk_en_o = st_r.clk;
    assign sim_clk_run_o = st_r.sim_run;
    assign periph_rst_n_o = st_r.per_rst_n;
    assign core_rst_n_o = st_r.core_rst_n;
    assign mem_read_block_o = st_r.secure;
    assign debug_disable_o = st_r.dbg_dis;
    assign jtag_active_o = st_r.jtag_on;
    assign power_mode_o = st_r.mode;
    assign irq_o = st_r.irq;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n_s);

    a_second_can_clock_enable_gate_off: assert property (clk_en && !st_nxt.pce2 |=> !clk_en_o.second_can_clock_enable) // RQ1
        else $error("second CAN clock runs while gated off");
    a_second_can_clock_enable_needs_periph: assert property (clk_en_o.second_can_clock_enable |-> clk_en_o.periph) // RQ1
        else $error("second CAN clock without peripheral clock");
    a_pce2_reserved: assert property (wb_rsp_o.ack && $past(idx) == CPRS_IDX_PCE2
        |-> wb_rsp_o.dat[31:1] == 31'h00000000) // RQ2
        else $error("reserved gate bits read nonzero");
    a_half_rate_clk: assert property (clk_en && clk_en_o.periph |=> !clk_en_o.periph) // RQ3
        else $error("peripheral clock above half rate");
    a_run_clocks_match: assert property (st_r.mode == CPRS_MD_RUN && st_r.sim_run && !st_r.clk.periph
        |-> clk_en_o.core == clk_en_o.periph) // RQ4 RQ5
        else $error("core and peripheral clocks differ in run");
    a_wait_core_off: assert property (st_r.mode == CPRS_MD_WAIT |-> !clk_en_o.core) // RQ6
        else $error("core clock active in wait");
    a_wait_wake_up: assert property (clk_en && st_r.mode == CPRS_MD_WAIT && periph_irq_i
        |=> st_r.mode == CPRS_MD_RUN && st_r.stat[CPRS_IRQ_WAIT_WAKE]) // RQ6
        else $error("interrupt did not wake from wait");
    a_stop_holds: assert property (clk_en && st_r.mode == CPRS_MD_STOP && !st_r.can_l && !st_r.nci_l
        && !watchdog_rst_i && !sw_rst |=> st_r.mode == CPRS_MD_STOP) // RQ7
        else $error("stop left without a wake source");
    a_stop_disabled: assert property (clk_en && st_r.mode == CPRS_MD_RUN && st_r.stop_dis
        && !wait_req_i |=> st_r.mode == CPRS_MD_RUN) // RQ18 RQ9
        else $error("disabled stop suspended clocks");
    a_seq_order: assert property (core_rst_n_o |-> periph_rst_n_o && sim_clk_run_o) // RQ11
        else $error("core released before peripherals");
    a_window_len: assert property (st_r.seq == CPRS_SQ_PERIPH |-> st_r.cnt <= CPRS_WINDOW_LAST) // RQ11
        else $error("release window overran");
    a_debug_secure: assert property (core_rst_n_o |-> debug_disable_o == mem_read_block_o) // RQ15 RQ16
        else $error("debug disable disagrees with security");

endmodule : cprs_top

`default_nettype wire

// [verif/cprs_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module cprs_partner (
    input wire logic mclk,
    input wire logic [1:0] power_mode,
    output logic stop_req,
    output logic wait_req,
    output logic periph_irq,
    output logic can_wake,
    output logic nonclk_irq,
    output logic watchdog_rst,
    output logic [15:0] flash_sec
);
    initial begin
        stop_req = 1'b0;
        wait_req = 1'b0;
        periph_irq = 1'b0;
        can_wake = 1'b0;
        nonclk_irq = 1'b0;
        watchdog_rst = 1'b0;
        flash_sec = 16'h0000;
    end

    // core executes one stop or wait instruction
    task instr(input logic stop);
        if (stop) stop_req <= 1'b1;
        else wait_req <= 1'b1;
        @(posedge mclk);
        stop_req <= 1'b0;
        wait_req <= 1'b0;
    endtask : instr

    // flash security bytes presented to the block
    task set_sec(input logic [15:0] v);
        flash_sec <= v;
    endtask : set_sec

    // 0 periph irq, 1 can traffic, 2 async irq, 3 watchdog pulse
    task wake(input int k);
        int n;
        n = 0;
        case (k)
            0: periph_irq <= 1'b1;
            1: can_wake <= 1'b1;
            2: nonclk_irq <= 1'b1;
            default: watchdog_rst <= 1'b1;
        endcase
        do begin
            @(posedge mclk);
            n++;
        end while (power_mode !== 2'h0 && n < 20 && k != 3);
        periph_irq <= 1'b0;
        can_wake <= 1'b0;
        nonclk_irq <= 1'b0;
        watchdog_rst <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : wake
endmodule : cprs_partner
`default_nettype wire

// [verif/clock_power_reset_security_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module clock_power_reset_security_tb
    import cprs_pkg::*;
;
    localparam logic [7:0] A_CTL = {CPRS_IDX_CONTROL, 2'b00};
    localparam logic [7:0] A_STAT = {CPRS_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_IRQS = {CPRS_IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] A_MASK = {CPRS_IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] A_PCE2 = {CPRS_IDX_PCE2, 2'b00};
    localparam int POR_EXT = 8;
    localparam int LIMIT = 20000;
    logic mclk, reset_n, por_n, clk_en, sim_run, per_rst_n, core_rst_n, mrb, dbg, jtag, irq;
    logic stop_req, wait_req, pirq, can_wake, nci, wdog;
    logic [1:0] mode;
    logic [15:0] fsec, xs_r;
    logic [31:0] rd;
    cprs_wb_req_t wb_req;
    cprs_wb_rsp_t wb_rsp;
    cprs_clk_en_t ce;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_por, n_ext, n, k, c, p, q;

    cprs_top #(.POR_EXTEND_CYCLES(POR_EXT)) cprs_top_i (
        .mclk(mclk), .reset_n(reset_n), .por_n(por_n), .clk_en(clk_en),
        .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .watchdog_rst_i(wdog), .stop_req_i(stop_req),
        .wait_req_i(wait_req), .periph_irq_i(pirq), .can_wake_i(can_wake), .nonclk_irq_i(nci),
        .flash_sec_i(fsec), .clk_en_o(ce), .sim_clk_run_o(sim_run), .periph_rst_n_o(per_rst_n),
        .core_rst_n_o(core_rst_n), .mem_read_block_o(mrb), .debug_disable_o(dbg),
        .jtag_active_o(jtag), .power_mode_o(mode), .irq_o(irq)
    );

    cprs_partner cprs_partner_i (
        .mclk(mclk), .power_mode(mode), .stop_req(stop_req), .wait_req(wait_req),
        .periph_irq(pirq), .can_wake(can_wake), .nonclk_irq(nci), .watchdog_rst(wdog),
        .flash_sec(fsec)
    );

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    function automatic logic [15:0] xorshift(input logic [15:0] s);
        logic [15:0] t;
        t = s ^ (s << 7);
        t = t ^ (t >> 9);
        return t ^ (t << 8);
    endfunction : xorshift

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // classic single cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
        do @(posedge mclk); while (wb_rsp.ack !== 1'b1);
        r = wb_rsp.dat;
        wb_req <= '0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        wb(1'b1, a, {16'h0000, d}, r);
    endtask : wr

    // n: cycles until core release, m: cycles peripherals run ahead of core
    task automatic wait_up(output int n, output int m);
        n = 0;
        m = 0;
        do begin
            @(posedge mclk);
            n++;
            if (per_rst_n === 1'b1 && core_rst_n !== 1'b1) begin
                m++;
            end
        end while (core_rst_n !== 1'b1);
    endtask : wait_up

    task automatic do_reset(input logic por, output int n, output int m);
        @(posedge mclk);
        reset_n <= 1'b0;
        por_n <= ~por;
        repeat (16) @(posedge mclk);
        check({per_rst_n, core_rst_n, sim_run, irq}, 32'h0);
        reset_n <= 1'b1;
        por_n <= 1'b1;
        wait_up(n, m);
    endtask : do_reset

    task automatic count4();
        c = 0;
        p = 0;
        q = 0;
        repeat (4) begin
            @(posedge mclk);
            c += int'(ce.core);
            p += int'(ce.second_can_clock_enable);
            q += int'(ce.periph);
        end
    endtask : count4

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        reset_n = 1'b0;
        por_n = 1'b0;
        clk_en = 1'b1;
        wb_req = '0;
        xs_r = 16'h580B;
        cprs_partner_i.set_sec(CPRS_SEC_LOCK_KEY);
        do_reset(1'b1, n_por, k);
        check(k, 2 * CPRS_WINDOW_CYCLES);
        check({mrb, dbg, jtag}, 32'h7);
        wb(1'b0, A_STAT, 32'h0, rd);
        check(rd, (32'h1 << CPRS_STAT_SECURE) | (32'h1 << CPRS_STAT_READY));
        wb(1'b0, A_PCE2, 32'h0, rd);
        check(rd, 32'(CPRS_PCE2_RST));
        repeat (12) begin
            xs_r = xorshift(xs_r);
            wr(A_PCE2, xs_r);
            wb(1'b0, A_PCE2, 32'h0, rd);
            check(rd, {31'h0, xs_r[CPRS_PCE2_SECOND_CAN_CLOCK_ENABLE]});
            count4();
            check(p, xs_r[CPRS_PCE2_SECOND_CAN_CLOCK_ENABLE] ? 2 : 0);
            check(q, 2);
            check(c, 2);
        end
        wr(A_IRQS, 16'h000F);
        wr(A_MASK, 16'h000F);
        check(irq, 1'b0);
        cprs_partner_i.instr(1'b0);
        @(posedge mclk);
        check({mode, ce.core}, {2'(CPRS_MD_WAIT), 1'b0});
        count4();
        check(q, 2);
        cprs_partner_i.wake(0);
        check({mode, irq}, {2'(CPRS_MD_RUN), 1'b1});
        wb(1'b0, A_IRQS, 32'h0, rd);
        check(rd, 32'h1 << CPRS_IRQ_WAIT_WAKE);
        wr(A_IRQS, 16'h000F);
        for (k = 1; k < 3; k++) begin
            cprs_partner_i.instr(1'b1);
            repeat (6) @(posedge mclk);
            check({mode, ce.periph, ce.core}, {2'(CPRS_MD_STOP), 2'b00});
            cprs_partner_i.wake(k);
            check(mode, 32'(CPRS_MD_RUN));
        end
        wb(1'b0, A_IRQS, 32'h0, rd);
        check(rd, 32'h1 << CPRS_IRQ_STOP_WAKE);
        wr(A_CTL, 16'h0007);
        wr(A_CTL, 16'h0000);
        wb(1'b0, A_CTL, 32'h0, rd);
        check(rd, 32'h7);
        cprs_partner_i.instr(1'b1);
        @(posedge mclk);
        check(mode, 32'(CPRS_MD_RUN));
        cprs_partner_i.instr(1'b0);
        @(posedge mclk);
        check(mode, 32'(CPRS_MD_RUN));
        wr(A_PCE2, 16'h0000);
        wr(A_CTL, 16'h0008);
        wait_up(n, k);
        check(k, 2 * CPRS_WINDOW_CYCLES);
        wb(1'b0, A_CTL, 32'h0, rd);
        check(rd, 32'h0);
        wb(1'b0, A_PCE2, 32'h0, rd);
        check(rd, 32'(CPRS_PCE2_RST));
        wr(A_IRQS, 16'h000F);
        cprs_partner_i.wake(3);
        wait_up(n, k);
        check(k, 2 * CPRS_WINDOW_CYCLES);
        wb(1'b0, A_IRQS, 32'h0, rd);
        check(rd, (32'h1 << CPRS_IRQ_WDOG) | (32'h1 << CPRS_IRQ_SEQ_DONE));
        wr(A_CTL, 16'h0007);
        xs_r = xorshift(xs_r);
        cprs_partner_i.set_sec(CPRS_SEC_LOCK_KEY ^ (xs_r | 16'h0001));
        do_reset(1'b0, n_ext, k);
        check(n_por - n_ext, POR_EXT - 1);
        check({mrb, dbg, jtag}, 32'h1);
        wb(1'b0, A_CTL, 32'h0, rd);
        check(rd, 32'h0);
        wb(1'b0, A_PCE2, 32'h0, rd);
        check(rd, 32'(CPRS_PCE2_RST));
        conclude();
    end
endmodule : clock_power_reset_security_tb
`default_nettype wire
